// file: test/adcm_mcu_model.sv
/*
  adcm_mcu_model: controller side of the start/busy link, drives the start pin.
  Assumes its tasks are called by the bench just after a rising clock edge.
*/
`timescale 1ns/10ps
module adcm_mcu_model (
  input wire logic clk_i,
  output logic start_n_o
);
  // pin idles high so the first fall after reset is a real edge
  initial begin
    start_n_o = 1'b1;
  end
  // quiet acquisition gap, then pull the start pin low
  task automatic fall(input int gap);
    repeat (gap) @(posedge clk_i);
    start_n_o <= 1'b0;
  endtask
  // release: before busy falls picks mode one, after it wakes the device
  task automatic rise();
    start_n_o <= 1'b1;
  endtask
endmodule

// file: test/tb_adc_conversion_mode_control.sv
/*
  tb_adc_conversion_mode_control: self-checking bench for adcm_conv_ctrl.
  Assumes the package timing constants; the comparator is an ideal analog input.
*/
`timescale 1ns/10ps
module tb_adc_conversion_mode_control;
  import adcm_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ld = 1'b0;
  logic start_n, cmp, busy, hold, pdn, valid;
  logic [2:0] addr = 3'h0;
  logic [2:0] sel;
  logic [9:0] dac, res;
  logic [9:0] vin = 10'h000;
  int num_errors = 0;
  int n_checks = 0;
  // ideal comparator: input at or above the trial code
  assign cmp = (vin >= dac);
  initial begin
    forever #12.5 clk = ~clk;
  end
  adcm_mcu_model mcu (.clk_i(clk), .start_n_o(start_n));
  adcm_conv_ctrl DUT (.CLK_I(clk), .RSTN_I(rstn), .CONVERSION_START_N_I(start_n), .COMPARATOR_I(cmp),
    .CHAN_LOAD_I(ld), .CHAN_ADDR_I(addr), .BUSY_O(busy), .HOLD_O(hold), .POWER_DOWN_O(pdn),
    .CHAN_SEL_O(sel), .DAC_CODE_O(dac), .RESULT_O(res), .RESULT_VALID_O(valid));
  // closing report
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // compare one result
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // a wait that used up its bound ends the run
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      chk(11'(n), 11'(lim - 1));
      end_of_test();
    end
  endtask
  // load a channel address, selection follows one cycle later
  task automatic load(input logic [2:0] a);
    @(posedge clk);
    ld <= 1'b1;
    addr <= a;
    @(posedge clk);
    ld <= 1'b0;
    #1;
    chk(11'(sel), 11'(a));
    $display("test load %h done", a);
  endtask
  // one conversion: measure busy, check result and power mode
  task automatic conv(input logic [9:0] v, input bit mode2, input bit glitch, input int len);
    int n;
    @(posedge clk);
    vin <= v;
    mcu.fall(5);
    n = 0;
    while (busy !== 1'b1 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    bound(n, 10);
    chk(11'(hold), 11'h001);
    n = 0;
    while (busy === 1'b1 && n < 2000) begin
      @(posedge clk);
      if (n == 8 && !mode2) mcu.rise();
      if (n == 100 && glitch) mcu.fall(0);
      if (n == 104 && glitch) mcu.rise();
      #1;
      n++;
    end
    bound(n, 2000);
    chk(11'(n), 11'(len));
    chk(11'(valid), 11'h001);
    chk(11'(hold), 11'h000);
    chk(11'(res), 11'(v));
    chk(11'(pdn), 11'(mode2));
    repeat (6) @(posedge clk);
    #1;
    chk(11'(busy), 11'h000);
    chk(11'(valid), 11'h000);
    if (mode2) begin
      chk(11'(pdn), 11'h001);
      @(posedge clk);
      mcu.rise();
      n = 0;
      while (pdn === 1'b1 && n < 8) begin
        @(posedge clk);
        #1;
        n++;
      end
      bound(n, 8);
      chk(11'(pdn), 11'h000);
    end
    $display("test conv %h mode2 %0d done", v, mode2);
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk(11'(sel), 11'(ADCM_CH_TEMP));
    chk(11'(busy), 11'h000);
    conv(10'h200, 1'b0, 1'b1, ADCM_CONV_TEMP_CYC);
    // consumer side: code 0x200 reads as 25 degrees
    chk(11'(res / 10'h004) - 11'h067, 11'h019);
    load(3'h1);
    conv(10'h3ff, 1'b1, 1'b0, ADCM_CONV_ANA_CYC);
    conv(10'h000, 1'b0, 1'b0, ADCM_CONV_ANA_CYC);
    load(3'h0);
    conv(10'h155, 1'b1, 1'b0, ADCM_CONV_TEMP_CYC);
    end_of_test();
  end
endmodule

// file: verilog/adcm_conv_ctrl.sv
/*
  adcm_conv_ctrl: conversion sequencing and power-mode control of a 10-bit SAR converter.
  Assumes the start pin is asynchronous, the comparator and channel load come from
  logic on CLK_I, and the analog section obeys HOLD_O, DAC_CODE_O and POWER_DOWN_O.
*/
// Operation
// [R01] start falling edge: hold the sampler, begin conversion, busy high until done
// [R02] temperature conversion keeps busy high 27 us, longer than analog 9 us
// [R03] acquisition restarts when conversion ends, lasts until next start falling edge
// [R04] controller leaves at least 100 ns acquisition before next start
// [R05] results are straight binary over 1024 codes, whole-LSB transitions
// [R06] loading channel address 000 selects the temperature sensor
// [R07] after reset the channel selection is the temperature sensor
// [R08] consumer computes degrees as code divided by four minus 103
// [R09] start level at conversion end selects the mode for that conversion
// [R10] start already high when busy falls: stay powered
// [R11] first mode: controller waits 100 ns after serial read before start
// [R12] start still low when busy falls: power down as busy deasserts
// [R13] powered down: rising start edge powers the device up again
// [R14] start falling edges during busy are ignored, conversion continues
`timescale 1ns/10ps
module adcm_conv_ctrl
  import adcm_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic CONVERSION_START_N_I,
  input wire logic COMPARATOR_I,
  input wire logic CHAN_LOAD_I,
  input wire logic [2:0] CHAN_ADDR_I,
  output logic BUSY_O,
  output logic HOLD_O,
  output logic POWER_DOWN_O,
  output logic [2:0] CHAN_SEL_O,
  output logic [9:0] DAC_CODE_O,
  output logic [9:0] RESULT_O,
  output logic RESULT_VALID_O
);
  adcm_reg_t r;
  adcm_reg_t n;
  logic start_s;
  logic start_fall;
  logic start_rise;
  logic [9:0] decided;

  // start pin crosses into the clock domain
  adcm_sync2 u_start_sync (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .d_i(CONVERSION_START_N_I),
    .q_o(start_s)
  );

  // edges of the synchronised start level
  assign start_fall = r.start_prev & ~start_s;
  assign start_rise = ~r.start_prev & start_s;

  // next state of the whole controller
  always_comb begin
    n = r;
    n.valid = 1'b0;
    n.start_prev = start_s;
    decided = r.dac;
    if (CHAN_LOAD_I) begin
      n.chan = CHAN_ADDR_I; // R06
    end
    case (r.st)
      ADCM_ACQ: begin
        if (start_rise && r.pdown) begin
          n.pdown = 1'b0; // R13
        end
        if (start_fall) begin
          n.st = ADCM_CONV; // R01
          n.busy = 1'b1;
          n.hold = 1'b1;
          n.pdown = 1'b0;
          n.temp = (r.chan == ADCM_CH_TEMP); // R06
          n.step = (r.chan == ADCM_CH_TEMP) ? ADCM_STEP_TEMP - 7'h1 : ADCM_STEP_ANA - 7'h1; // R02
          n.bitn = ADCM_TOP_BIT;
          n.dac = ADCM_DAC_MID;
        end
      end
      ADCM_CONV: begin
        // start edges are not looked at here R14
        if (r.step != 7'h0) begin
          n.step = r.step - 7'h1;
        end else begin
          // keep the trial bit only when the input is at or above the trial code R05
          if (!COMPARATOR_I) begin
            decided[r.bitn] = 1'b0;
          end
          n.dac = decided;
          if (r.bitn == 4'h0) begin
            n.st = ADCM_ACQ; // R03
            n.busy = 1'b0;
            n.hold = 1'b0;
            n.result = decided; // R05
            n.valid = 1'b1;
            n.pdown = ~start_s; // R09 R10 R12
          end else begin
            n.bitn = r.bitn - 4'h1;
            n.dac[r.bitn - 4'h1] = 1'b1;
            n.step = r.temp ? ADCM_STEP_TEMP - 7'h1 : ADCM_STEP_ANA - 7'h1; // R02
          end
        end
      end
      default: begin
        n.st = ADCM_ACQ;
      end
    endcase
  end

  // state register; reset selects the temperature channel
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      r <= '{st: ADCM_ACQ, busy: 1'b0, hold: 1'b0, pdown: 1'b0, chan: ADCM_CH_TEMP, temp: 1'b1,
             step: 7'h0, bitn: 4'h0, dac: 10'h000, result: 10'h000, valid: 1'b0,
             start_prev: 1'b1}; // R07
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state flops
  assign BUSY_O = r.busy;
  assign HOLD_O = r.hold;
  assign POWER_DOWN_O = r.pdown;
  assign CHAN_SEL_O = r.chan;
  assign DAC_CODE_O = r.dac;
  assign RESULT_O = r.result;
  assign RESULT_VALID_O = r.valid;

  // busy length counter read only by the checks
  // long durations are counted here so that no property needs a long repetition
  logic [10:0] busy_len_r;
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      busy_len_r <= 11'h000;
    end else if (r.busy) begin
      busy_len_r <= busy_len_r + 11'h001;
    end else begin
      busy_len_r <= 11'h000;
    end
  end

  // all checks share the system clock; all but a_reset_chan stay quiet while reset is low
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  sequence s_start_idle;
    !r.busy && start_fall;
  endsequence

  sequence s_conv_end;
    r.busy ##1 !r.busy;
  endsequence

  a_start_sets_busy: assert property (s_start_idle |=> r.busy && r.hold && !r.pdown) // R01
    else $error("start edge did not begin a conversion");

  a_temp_busy_len: assert property ((r.busy && r.temp) ##1 !r.busy |-> // R02
    $past(busy_len_r) == 11'(ADCM_CONV_TEMP_CYC - 1))
    else $error("temperature conversion length wrong");

  a_ana_busy_len: assert property ((r.busy && !r.temp) ##1 !r.busy |-> // R02
    $past(busy_len_r) == 11'(ADCM_CONV_ANA_CYC - 1))
    else $error("analog conversion length wrong");

  a_acq_restart: assert property (s_conv_end |-> !r.hold && r.valid ##1 !r.hold) // R03
    else $error("acquisition not restarted at conversion end");

  a_result_binary: assert property (r.valid |-> r.result == // R05
    ($past(COMPARATOR_I) ? $past(r.dac) : ($past(r.dac) & 10'h3fe)))
    else $error("result is not the final trial code");

  a_temp_select: assert property (CHAN_LOAD_I && CHAN_ADDR_I == ADCM_CH_TEMP |=> r.chan == ADCM_CH_TEMP) // R06
    else $error("address 000 did not select the sensor");

  a_reset_chan: assert property (@(posedge CLK_I) disable iff (1'b0) // R07
    !RSTN_I |=> r.chan == ADCM_CH_TEMP)
    else $error("reset channel is not the sensor");

  a_mode_one: assert property (r.busy && n.st == ADCM_ACQ && start_s |=> !r.pdown && !r.busy) // R10
    else $error("first mode powered down");

  a_mode_two: assert property (r.busy && n.st == ADCM_ACQ && !start_s |=> r.pdown && !r.busy) // R12
    else $error("second mode did not power down with busy");

  a_power_up: assert property (r.pdown && !r.busy && start_rise |=> !r.pdown) // R13
    else $error("rising start did not power up");

  a_ignore_start: assert property (r.busy && start_fall && r.step != 7'h0 |=> // R14
    r.busy && r.step == $past(r.step) - 7'h1)
    else $error("start edge disturbed a conversion");

  // the sampler holds exactly while a conversion runs, and is powered throughout
  a_hold_tracks: assert property (r.hold == r.busy) // R01
    else $error("hold and busy differ");

  a_awake_busy: assert property (r.busy |-> !r.pdown) // R12
    else $error("powered down during a conversion");

  // every conversion opens with the top bit as its first trial
  a_first_trial: assert property (s_start_idle |=> r.dac == ADCM_DAC_MID) // R05
    else $error("first trial code is not midscale");

  // conversion length is latched from the channel when the start edge is taken
  a_temp_latch: assert property (s_start_idle |=> r.temp == ($past(r.chan) == ADCM_CH_TEMP)) // R02
    else $error("conversion length not taken from the channel");

  a_chan_keep: assert property (!CHAN_LOAD_I |=> r.chan == $past(r.chan)) // R06
    else $error("channel changed without a load");

  // the result strobe stands for a single cycle
  a_valid_pulse: assert property (r.valid |=> !r.valid) // R03
    else $error("result strobe longer than one cycle");

  // busy stays high through every trial step of a running conversion
  a_busy_steps: assert property (r.busy && (r.bitn != 4'h0 || r.step != 7'h0) |=> r.busy) // R14
    else $error("conversion ended before its last trial");
endmodule

// file: verilog/adcm_pkg.sv
/*
  adcm_pkg: constants and state types shared by the conversion and mode control block.
  Assumes a 40 MHz system clock; the conversion timing is counted in cycles of that clock.
*/
package adcm_pkg;
  // clock period in picoseconds
  localparam int ADCM_CLK_PS = 25000;
  // conversion times in nanoseconds
  localparam int ADCM_CONV_ANA_NS = 9000;
  localparam int ADCM_CONV_TEMP_NS = 27000;
  // number of result bits, trial steps per conversion
  localparam int ADCM_BITS = 10;
  // cycles of one conversion and of one trial step
  localparam int ADCM_CONV_ANA_CYC = (ADCM_CONV_ANA_NS * 1000) / ADCM_CLK_PS;
  localparam int ADCM_CONV_TEMP_CYC = (ADCM_CONV_TEMP_NS * 1000) / ADCM_CLK_PS;
  localparam logic [6:0] ADCM_STEP_ANA = 7'(ADCM_CONV_ANA_CYC / ADCM_BITS);
  localparam logic [6:0] ADCM_STEP_TEMP = 7'(ADCM_CONV_TEMP_CYC / ADCM_BITS);
  // channel address of the temperature sensor, also the reset selection
  localparam logic [2:0] ADCM_CH_TEMP = 3'h0;
  // first trial code: the result's top bit
  localparam logic [9:0] ADCM_DAC_MID = 10'h200;
  localparam logic [3:0] ADCM_TOP_BIT = 4'h9;

  typedef enum logic {ADCM_ACQ, ADCM_CONV} adcm_state_t;

  typedef struct packed {
    adcm_state_t st;
    logic busy;
    logic hold;
    logic pdown;
    logic [2:0] chan;
    logic temp;
    logic [6:0] step;
    logic [3:0] bitn;
    logic [9:0] dac;
    logic [9:0] result;
    logic valid;
    logic start_prev;
  } adcm_reg_t;
endpackage

// file: verilog/adcm_sync2.sv
/*
  adcm_sync2: two flip-flop synchroniser for one level from outside the clock domain.
  Assumes the input may change at any time; only the second stage is visible.
*/
`timescale 1ns/10ps
module adcm_sync2 (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;

  // idle level of the active-low start pin is high
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_r <= 1'b1;
      q_o <= 1'b1;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule
